// file: rtl/gfs_defs.vh
// gfs_defs.vh: constants for the gate fault supervisor
// assumes a 200 MHz system clock; included by bare name
`ifndef GFS_DEFS_VH
`define GFS_DEFS_VH
`define GFS_CLK_MHZ        200
`define GFS_TICK_US        1000
`define GFS_TICK_CYC       (`GFS_TICK_US * `GFS_CLK_MHZ)
`define GFS_LINK_ALARM_MS  60000
`define GFS_RUN_HOLD_MS    300000
`define GFS_CHIRP_MS       5000
`define GFS_BLINK_MS       500
`define GFS_CHIRP_LEN_MS   50
`define GFS_BEEP_NORM_MS   500
`define GFS_BEEP_FAST_MS   250
`define GFS_DBL_B1_MS      100
`define GFS_DBL_GAP_MS     200
`define GFS_DBL_B2_MS      300
`define GFS_CODE_NONE      8'hff
`define GFS_CODE_REVERSAL  8'h00
`define GFS_CODE_RUN_OPEN  8'h01
`define GFS_CODE_RUN_CLOSE 8'h02
`define GFS_CODE_LINK      8'h03
`define GFS_CODE_FIRE      8'h04
`define GFS_CODE_MAINS     8'h05
`define GFS_CODE_PEER_TRAP 8'h06
`define GFS_CODE_LOW_AC    8'h07
`define GFS_CODE_TRAP_IN   8'h08
`define GFS_CODE_COMPAT    8'h09
`define GFS_CODE_STORE     8'h10
`define GFS_CODE_MOTOR_MIS 8'h11
`define GFS_CODE_MOTOR_BAD 8'h12
`endif

// file: rtl/gfs_supervisor.v
// gfs_supervisor.v: fault supervision, error code and sounder control
// assumes all inputs synchronous to clk_i and button inputs are pulses
// Functional notes
// - reset button clears obstruction and overrun lockouts and storage fault, never moves gate
// - link loss blinks LED, only override moves
// - sensor trouble flagged, motion stays permitted
// - prestart beeps double rate under trouble
// - run alarm fast, lasts five minutes after
// - trouble annunciation clears when condition clears
// - run overrun locks out, constant alarm
// - double beep each five seconds until run
// - two reversals: code 00, alarm, disabled
// - link loss: code 03, alarm one minute
// - override full open: code 04 until stop
// - mains loss: code 05 until battery good
// - peer entrapment: code 06 until cleared
// - low supply: code 07 until supply good
// - input during lockout: code 08 until stop
// - compatibility mismatch: code 09 until reset
// - storage fault: code 10, reset retries
// - motor mismatch: code 11, retry on move
// - motor failure: code 12 permanently
// - double obstruction locks out, constant beeper
`timescale 1ns/1ps
`include "gfs_defs.vh"
module gfs_supervisor #(
   parameter TICK_CYC     = `GFS_TICK_CYC,      // cycles per millisecond
   parameter LINK_ALARM_MS = `GFS_LINK_ALARM_MS, // link alarm duration
   parameter RUN_HOLD_MS  = `GFS_RUN_HOLD_MS,   // run alarm hold after stop
   parameter CHIRP_MS     = `GFS_CHIRP_MS       // chirp and double beep period
) (
   input  wire       clk_i,          // system clock
   input  wire       rst_n_i,        // synchronous reset, active low
   input  wire       stop_btn_i,     // stop button press pulse
   input  wire       reset_btn_i,    // cover reset button press pulse
   input  wire       paired_i,       // dual gate installation enabled
   input  wire       peer_link_ok_i, // peer link connection healthy
   input  wire       override_i,     // emergency override input active
   input  wire       full_open_i,    // gate at open limit
   input  wire       cmd_open_i,     // user open or run command pulse
   input  wire       cmd_close_i,    // user close command pulse
   input  wire       input_act_i,    // any activation input pulse
   input  wire       obstruct_i,     // obstruction trigger pulse
   input  wire       reversal_i,     // safety reversal pulse
   input  wire       peer_reversal_i,// peer reversal pulse
   input  wire       limit_reached_i,// open or close limit reached pulse
   input  wire       runtime_over_i, // maximum run time exceeded pulse
   input  wire       moving_open_i,  // gate running in open direction
   input  wire       moving_i,       // gate running in either direction
   input  wire       prestart_i,     // pre-start delay active
   input  wire       mains_fail_i,   // fail safe action on mains loss pulse
   input  wire       batt_good_i,    // battery above 24 VDC
   input  wire       supply_good_i,  // low voltage supply above 20 VAC
   input  wire       peer_trap_i,    // peer controller in entrapment
   input  wire       compat_err_i,   // peer compatibility mismatch pulse
   input  wire       store_err_i,    // settings storage fault pulse
   input  wire       motor_mis_i,    // motor type mismatch seen
   input  wire       motor_bad_i,    // motor failure detected pulse
   input  wire       sens_low_batt_i,// obstacle sensor low battery
   input  wire       sens_tamper_i,  // obstacle sensor tamper
   input  wire       sens_missing_i, // obstacle sensor hourly report missed
   output reg        motion_ok_o,    // normal gate motion permitted
   output reg        override_ok_o,  // override motion permitted
   output reg        beeper_o,       // sounder drive
   output reg        link_led_o,     // peer link indicator
   output reg        run_led_o,      // max run time indicator
   output reg        trouble_o,      // sensor trouble flag
   output reg [7:0]  err_code_o      // two digit error code, ff when none
);
   localparam S_IDLE  = 3'b001;   // no run-time indication
   localparam S_ALARM = 3'b010;   // overrun lockout, constant alarm
   localparam S_DBL   = 3'b100;   // double beep until next operation
   localparam HALF_MS = `GFS_BLINK_MS;

   wire        tick;
   reg  [2:0]  run_st;
   reg         run_open;
   reg         rev_cnt;
   reg         obs_cnt;
   reg         trap;
   reg         f_rev, f_link_al, f_fire, f_mains, f_low_ac, f_trap_in;
   reg         f_compat, f_store, f_motor_mis, f_motor_bad;
   reg  [31:0] link_ms, hold_ms, chirp_ms, blink_ms;
   reg  [8:0]  beep_ms;
   reg         moving_d;
   reg  [7:0]  next_code;
   reg         next_beep;
   wire        clear_btn = stop_btn_i | reset_btn_i;
   wire        link_fail = paired_i & ~peer_link_ok_i;
   wire        trouble   = sens_low_batt_i | sens_tamper_i | sens_missing_i;
   wire        go_cmd    = cmd_open_i | cmd_close_i;

   gfs_timer #(
      .TICK_CYC (TICK_CYC)
   ) u_timer (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .tick_o  (tick)
   );

   // returns one while the pattern counter sits in the given window
   function in_win;
      input [31:0] t;
      input [31:0] lo;
      input [31:0] hi;
      begin
         in_win = (t >= lo) && (t < hi);
      end
   endfunction

   // entrapment and overrun lockout; buttons only clear, never start
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         trap     <= 1'b0;
         obs_cnt  <= 1'b0;
         run_st   <= S_IDLE;
         run_open <= 1'b0;
      end else begin
         case (run_st)
            S_IDLE: begin
               if (runtime_over_i) begin
                  run_st   <= S_ALARM;
                  run_open <= moving_open_i;
               end
            end
            S_ALARM: begin
               // button clears lockout only; a new overrun wins
               if (runtime_over_i)
                  run_open <= moving_open_i;
               else if (clear_btn)
                  run_st <= S_DBL;
            end
            S_DBL: begin
               if (runtime_over_i) begin
                  run_st   <= S_ALARM;
                  run_open <= moving_open_i;
               end else if (go_cmd)
                  run_st <= S_IDLE;
            end
            default: run_st <= S_IDLE;
         endcase
         // second obstruction before limit locks out
         if (obstruct_i && obs_cnt)
            trap <= 1'b1;
         else if (clear_btn)
            trap <= 1'b0;
         if (obstruct_i)
            obs_cnt <= 1'b1;
         else if (limit_reached_i || clear_btn)
            obs_cnt <= 1'b0;
      end
   end

   // latched fault flags; a set in the same cycle as a clear wins
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         rev_cnt     <= 1'b0;
         f_rev       <= 1'b0;
         f_fire      <= 1'b0;
         f_mains     <= 1'b0;
         f_low_ac    <= 1'b0;
         f_trap_in   <= 1'b0;
         f_compat    <= 1'b0;
         f_store     <= 1'b0;
         f_motor_mis <= 1'b0;
         f_motor_bad <= 1'b0;
      end else begin
         if ((reversal_i || peer_reversal_i) && rev_cnt)
            f_rev <= 1'b1;
         else if (stop_btn_i)
            f_rev <= 1'b0;
         if (reversal_i || peer_reversal_i)
            rev_cnt <= 1'b1;
         else if (stop_btn_i || limit_reached_i)
            rev_cnt <= 1'b0;
         if (override_i && full_open_i)
            f_fire <= 1'b1;
         else if (stop_btn_i)
            f_fire <= 1'b0;
         if (mains_fail_i)
            f_mains <= 1'b1;
         else if (batt_good_i)
            f_mains <= 1'b0;
         f_low_ac <= ~supply_good_i;
         if (input_act_i && (trap || run_st == S_ALARM))
            f_trap_in <= 1'b1;
         else if (stop_btn_i)
            f_trap_in <= 1'b0;
         if (compat_err_i)
            f_compat <= 1'b1;
         if (store_err_i)
            f_store <= 1'b1;
         else if (reset_btn_i)
            f_store <= 1'b0;
         // retry motor check on next move
         if (motor_mis_i)
            f_motor_mis <= 1'b1;
         else if (go_cmd)
            f_motor_mis <= 1'b0;
         if (motor_bad_i)
            f_motor_bad <= 1'b1;
      end
   end

   // millisecond timers for link alarm, run hold, chirp and blink
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         link_ms   <= 32'h0;
         f_link_al <= 1'b0;
         hold_ms   <= 32'h0;
         chirp_ms  <= 32'h0;
         blink_ms  <= 32'h0;
         beep_ms   <= 9'h0;
         moving_d  <= 1'b0;
      end else begin
         moving_d <= moving_i;
         // alarm one minute or until stop
         if (!link_fail) begin
            link_ms   <= 32'h0;
            f_link_al <= 1'b0;
         end else if (link_ms == 32'h0 && !f_link_al) begin
            link_ms   <= 32'h1;
            f_link_al <= 1'b1;
         end else if (stop_btn_i || link_ms >= LINK_ALARM_MS)
            f_link_al <= 1'b0;
         else if (tick && f_link_al)
            link_ms <= link_ms + 32'h1;
         if (moving_d && !moving_i && trouble)
            hold_ms <= RUN_HOLD_MS;
         else if (!trouble || moving_i)
            hold_ms <= 32'h0;
         else if (tick && hold_ms != 32'h0)
            hold_ms <= hold_ms - 32'h1;
         if (tick)
            chirp_ms <= (chirp_ms >= CHIRP_MS - 1) ? 32'h0 :
                        chirp_ms + 32'h1;
         if (tick)
            blink_ms <= (blink_ms >= 2 * HALF_MS - 1) ? 32'h0 :
                        blink_ms + 32'h1;
         if (tick)
            beep_ms <= beep_ms + 9'h1;
      end
   end

   // severity priority encoder for the code
   always @* begin
      next_code = `GFS_CODE_NONE;
      if (f_motor_bad)
         next_code = `GFS_CODE_MOTOR_BAD;
      else if (f_rev || trap)
         next_code = `GFS_CODE_REVERSAL;
      else if (run_st == S_ALARM)
         next_code = run_open ? `GFS_CODE_RUN_OPEN : `GFS_CODE_RUN_CLOSE;
      else if (f_trap_in)
         next_code = `GFS_CODE_TRAP_IN;
      else if (peer_trap_i)
         next_code = `GFS_CODE_PEER_TRAP;
      else if (f_store)
         next_code = `GFS_CODE_STORE;
      else if (f_motor_mis)
         next_code = `GFS_CODE_MOTOR_MIS;
      else if (f_compat)
         next_code = `GFS_CODE_COMPAT;
      else if (link_fail)
         next_code = `GFS_CODE_LINK;
      else if (f_mains)
         next_code = `GFS_CODE_MAINS;
      else if (f_low_ac)
         next_code = `GFS_CODE_LOW_AC;
      else if (f_fire)
         next_code = `GFS_CODE_FIRE;
   end

   // sounder source; constant alarms outrank trouble patterns
   always @* begin
      next_beep = 1'b0;
      if (f_rev || trap || run_st == S_ALARM || f_link_al)
         next_beep = 1'b1;
      else if (trouble && (prestart_i || moving_i))
         next_beep = beep_ms[7];
      else if (trouble && hold_ms != 32'h0)
         next_beep = beep_ms[7];
      else if (prestart_i || moving_i)
         next_beep = beep_ms[8];
      else if (run_st == S_DBL)
         next_beep = in_win(chirp_ms, 32'h0, `GFS_DBL_B1_MS) ||
                     in_win(chirp_ms, `GFS_DBL_GAP_MS, `GFS_DBL_B2_MS);
      else if (trouble)
         next_beep = in_win(chirp_ms, 32'h0, `GFS_CHIRP_LEN_MS);
   end

   // registered outputs
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         motion_ok_o   <= 1'b0;
         override_ok_o <= 1'b0;
         beeper_o      <= 1'b0;
         link_led_o    <= 1'b0;
         run_led_o     <= 1'b0;
         trouble_o     <= 1'b0;
         err_code_o    <= `GFS_CODE_NONE;
      end else begin
         motion_ok_o   <= (next_code == `GFS_CODE_NONE);
         override_ok_o <= (next_code == `GFS_CODE_NONE) ||
                          (next_code == `GFS_CODE_LINK);
         beeper_o      <= next_beep;
         link_led_o    <= link_fail && (blink_ms < HALF_MS);
         run_led_o     <= (run_st == S_ALARM);
         trouble_o     <= trouble;
         err_code_o    <= next_code;
      end
   end
endmodule // gfs_supervisor

// file: rtl/gfs_timer.v
// gfs_timer.v: millisecond tick prescaler shared by all timed annunciations
// assumes a free running clock; tick is a one cycle pulse every millisecond
`timescale 1ns/1ps
`include "gfs_defs.vh"
module gfs_timer #(
   parameter TICK_CYC = `GFS_TICK_CYC
) (
   input  wire clk_i,    // system clock
   input  wire rst_n_i,  // synchronous reset, active low
   output reg  tick_o    // one cycle pulse per millisecond
);
   reg [31:0] cnt;

   // free running prescaler, wraps at the tick period
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         cnt    <= 32'h0;
         tick_o <= 1'b0;
      end else if (cnt == TICK_CYC - 1) begin
         cnt    <= 32'h0;
         tick_o <= 1'b1;
      end else begin
         cnt    <= cnt + 32'h1;
         tick_o <= 1'b0;
      end
   end
endmodule // gfs_timer

// file: verif/gfs_peer_model.sv
// gfs_peer_model.sv: behavioural peer gate controller
// assumes bench requests change just after a rising clock edge
`timescale 1ns/1ps
module gfs_peer_model (
   input  wire logic clk_i,     // system clock
   input  wire logic link_up_i, // keep the link healthy
   input  wire logic trap_i,    // peer sits in entrapment
   input  wire logic rev_i,     // request one peer reversal
   output logic      link_ok_o, // link status to supervisor
   output logic      trap_o,    // peer lockout level
   output logic      rev_o      // one cycle reversal pulse
);
   logic rev_q;
   initial {link_ok_o, trap_o, rev_o, rev_q} = 4'b1000;
   // status arrives one cycle late, as over a real link
   always @(posedge clk_i) begin
      link_ok_o <= link_up_i;
      trap_o    <= trap_i;
      rev_q     <= rev_i;
      rev_o     <= rev_i & ~rev_q; // only one pulse per request
   end
endmodule // gfs_peer_model

// file: verif/gfs_supervisor_props.sv
// gfs_supervisor_props.sv: port checks for the fault supervisor
// assumes one clock and the synchronous active low reset
`timescale 1ns/1ps
module gfs_supervisor_props (
   input wire logic       clk_i, rst_n_i, stop_btn_i, paired_i,
   input wire logic       peer_link_ok_i, runtime_over_i, moving_open_i,
   input wire logic       sens_low_batt_i, sens_tamper_i, sens_missing_i,
   input wire logic       motion_ok_o, override_ok_o, beeper_o,
   input wire logic       run_led_o, trouble_o,
   input wire logic [7:0] err_code_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // any sensor supervision condition
   wire s_any = sens_low_batt_i | sens_tamper_i | sens_missing_i;

   lock_alarm_a: assert property (
      err_code_o == 8'h00 |-> beeper_o && !motion_ok_o)
      else $error("lockout code without alarm");
   fault_stop_a: assert property (
      err_code_o != 8'hff |-> !motion_ok_o)
      else $error("motion allowed with a fault shown");
   // first edge after reset still shows reset values, so skip it
   no_fault_a: assert property (
      $past(rst_n_i) && err_code_o == 8'hff |-> motion_ok_o)
      else $error("motion blocked without a fault");
   open_over_a: assert property (
      runtime_over_i && moving_open_i
      |-> ##2 err_code_o inside {8'h01, 8'h00, 8'h12})
      else $error("opening overrun code wrong");
   close_over_a: assert property (
      runtime_over_i && !moving_open_i
      |-> ##2 err_code_o inside {8'h02, 8'h00, 8'h12})
      else $error("closing overrun code wrong");
   run_led_a: assert property (
      err_code_o inside {8'h01, 8'h02} |-> run_led_o && beeper_o)
      else $error("overrun without led and alarm");
   stop_clear_a: assert property (
      stop_btn_i && !runtime_over_i && err_code_o inside {8'h01, 8'h02}
      |-> ##2 !(err_code_o inside {8'h01, 8'h02}))
      else $error("stop did not clear overrun");
   trouble_set_a: assert property (
      s_any [*2] |-> trouble_o)
      else $error("sensor trouble not flagged");
   trouble_clr_a: assert property (
      !s_any [*2] |-> !trouble_o)
      else $error("sensor trouble not cleared");
   link_block_a: assert property (
      (paired_i && !peer_link_ok_i) [*3] |-> !motion_ok_o && override_ok_o)
      else $error("link loss motion gating wrong");
endmodule // gfs_supervisor_props

bind gfs_supervisor gfs_supervisor_props u_gfs_supervisor_props (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .stop_btn_i(stop_btn_i),
   .paired_i(paired_i), .peer_link_ok_i(peer_link_ok_i),
   .runtime_over_i(runtime_over_i), .moving_open_i(moving_open_i),
   .sens_low_batt_i(sens_low_batt_i), .sens_tamper_i(sens_tamper_i),
   .sens_missing_i(sens_missing_i), .motion_ok_o(motion_ok_o),
   .override_ok_o(override_ok_o), .beeper_o(beeper_o),
   .run_led_o(run_led_o), .trouble_o(trouble_o), .err_code_o(err_code_o));

// file: verif/gfs_supervisor_tb_top.sv
// gfs_supervisor_tb_top.sv: directed bench for the fault supervisor
// assumes a 1 ms tick shortened to two clocks
`timescale 1ns/1ps
module gfs_supervisor_tb_top;
   logic       clk_i = 0, rst_n_i = 0, paired = 0, ovr = 0, fopen = 0;
   logic       mv_open = 0, moving = 0, batt = 1, supply = 1, pre = 0;
   logic       s_lb = 0, s_tp = 0, s_ms = 0, link_up = 1, trap = 0;
   logic [14:0] pls = '0; // one bit per pulse input
   logic       link_ok, p_trap, p_rev, motion_ok, ovr_ok, beeper;
   logic       link_led, run_led, trouble, bh, lc;
   logic [7:0] code;
   int         err_total = 0, comparisons = 0, cycles = 0, nb = 0;

   gfs_peer_model u_gfs_peer_model (.clk_i(clk_i), .link_up_i(link_up),
      .trap_i(trap), .rev_i(pls[14]), .link_ok_o(link_ok),
      .trap_o(p_trap), .rev_o(p_rev));
   gfs_supervisor #(.TICK_CYC(2), .LINK_ALARM_MS(20), .RUN_HOLD_MS(600),
      .CHIRP_MS(400)) u_gfs_supervisor (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .stop_btn_i(pls[0]), .reset_btn_i(pls[1]), .paired_i(paired),
      .peer_link_ok_i(link_ok), .override_i(ovr), .full_open_i(fopen),
      .cmd_open_i(pls[2]), .cmd_close_i(pls[3]), .input_act_i(pls[4]),
      .obstruct_i(pls[5]), .reversal_i(pls[6]), .peer_reversal_i(p_rev),
      .limit_reached_i(pls[7]), .runtime_over_i(pls[8]),
      .moving_open_i(mv_open), .moving_i(moving), .prestart_i(pre),
      .mains_fail_i(pls[9]), .batt_good_i(batt), .supply_good_i(supply),
      .peer_trap_i(p_trap), .compat_err_i(pls[10]), .store_err_i(pls[11]),
      .motor_mis_i(pls[12]), .motor_bad_i(pls[13]), .sens_low_batt_i(s_lb),
      .sens_tamper_i(s_tp), .sens_missing_i(s_ms), .motion_ok_o(motion_ok),
      .override_ok_o(ovr_ok), .beeper_o(beeper), .link_led_o(link_led),
      .run_led_o(run_led), .trouble_o(trouble), .err_code_o(code));

   // 200 MHz clock
   always #2.5 clk_i = ~clk_i;
   // runs are about 13100 cycles, so this only cuts a hang
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 30000) begin
         err_total++;
         give_verdict();
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // a spare cycle after each pulse keeps repeats apart
   task automatic pulse(input int k);
      pls[k] = 1'b1;
      cyc(1);
      pls[k] = 1'b0;
      cyc(1);
   endtask
   task automatic chk(input string n, input logic [7:0] s, e);
      comparisons++;
      if (s !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
         err_total++;
      end
   endtask
   // notes beeper activity and toggles, and whether the link led moved
   task automatic watch(input int n);
      logic l0, b0;
      l0 = link_led;
      b0 = beeper;
      bh = 0;
      lc = 0;
      nb = 0;
      repeat (n) begin
         cyc(1);
         bh |= (beeper === 1'b1);
         lc |= (link_led !== l0);
         nb += (beeper !== b0);
         b0 = beeper;
      end
   endtask
   task automatic do_reset;
      rst_n_i = 0;
      cyc(16);
      rst_n_i = 1;
      cyc(2);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic t_overrun;
      for (int d = 0; d < 2; d++) begin
         chk("idle code", code, 8'hff);
         mv_open = (d == 0);
         moving = 1;
         pulse(8);
         moving = 0;
         chk("run code soon", code, d ? 8'h02 : 8'h01);
         cyc(1);
         chk("run code", code, d ? 8'h02 : 8'h01);
         chk("run led", run_led, 1);
         chk("run alarm", beeper, 1);
         pulse(d);
         cyc(1);
         chk("run clear", code, 8'hff);
         watch(900);
         chk("double beep", bh, 1);
         pulse(2 + d);
         watch(1000);
         chk("beep cancel", bh, 0);
      end
      $display("overrun test done");
   endtask
   task automatic t_lockout;
      pulse(6);
      pulse(7);
      pulse(6);
      chk("split reversals", code, 8'hff);
      pulse(14);
      cyc(3);
      chk("reversal code", code, 8'h00);
      pulse(0);
      chk("reversal clear", code, 8'hff);
      pulse(5);
      pulse(5);
      pulse(4);
      chk("trap code", code, 8'h00);
      chk("trap alarm", beeper, 1);
      pulse(1);
      chk("input lockout", code, 8'h08);
      pulse(0);
      cyc(1);
      chk("trap clear", code, 8'hff);
      $display("lockout test done");
   endtask
   task automatic t_codes;
      logic [7:0] cd [6] = '{8'h05, 8'h07, 8'h06, 8'h10, 8'h11, 8'h04};
      for (int i = 0; i < 6; i++) begin
         batt = (i != 0);
         supply = (i != 1);
         trap = (i == 2);
         {ovr, fopen} = {2{i == 5}};
         if (i == 0 || i == 3 || i == 4)
            pulse(i == 0 ? 9 : i + 8);
         cyc(4);
         ovr = 0; // code must outlive the override itself
         cyc(2);
         chk("fault code", code, cd[i]);
         chk("fault motion", motion_ok, 0);
         {batt, supply, trap} = 3'b110;
         if (i >= 3)
            pulse(i == 3 ? 1 : (i == 4 ? 2 : 0));
         fopen = 0;
         cyc(4);
         chk("fault clear", code, 8'hff);
      end
      $display("codes test done");
   endtask
   task automatic t_link;
      paired = 1;
      link_up = 0;
      cyc(4);
      chk("link code", code, 8'h03);
      chk("link override", ovr_ok, 1);
      chk("link alarm", beeper, 1);
      watch(1100);
      chk("link blink", lc, 1);
      chk("alarm ends", beeper, 0);
      link_up = 1;
      cyc(4);
      link_up = 0;
      cyc(4);
      pulse(0);
      chk("alarm hushed", beeper, 0);
      link_up = 1;
      paired = 0;
      cyc(4);
      chk("link clear", code, 8'hff);
      $display("link test done");
   endtask
   task automatic t_trouble;
      pre = 1;
      cyc(4);
      watch(1024);
      chk("normal prestart", nb, 2);
      s_tp = 1;
      cyc(4);
      watch(1024);
      chk("fast prestart", nb, 4);
      pre = 0;
      moving = 1;
      cyc(4);
      watch(1024);
      chk("fast run", nb, 4);
      moving = 0;
      cyc(4);
      watch(1024);
      chk("run hold", nb, 4);
      s_tp = 0;
      cyc(4);
      for (int k = 0; k < 3; k++) begin
         {s_lb, s_tp, s_ms} = 3'b100 >> k;
         cyc(3);
         chk("trouble flag", trouble, 1);
         chk("trouble motion", motion_ok, 1);
         watch(900);
         chk("idle chirp", bh, 1);
         {s_lb, s_tp, s_ms} = 3'b000;
         cyc(100); // a chirp already started is cut off as soon as trouble clears
         chk("trouble gone", trouble, 0);
      end
      watch(900);
      chk("chirp gone", bh, 0);
      $display("trouble test done");
   endtask
   task automatic t_fatal;
      pulse(13);
      pulse(0);
      pulse(1);
      chk("motor dead", code, 8'h12);
      do_reset();
      pulse(10);
      pulse(0);
      chk("compat code", code, 8'h09);
      do_reset();
      chk("compat clear", code, 8'hff);
      $display("fatal test done");
   endtask

   initial begin
      do_reset();
      t_overrun();
      t_lockout();
      t_codes();
      t_link();
      t_trouble();
      t_fatal();
      give_verdict();
   end
endmodule // gfs_supervisor_tb_top
